// [verification/uacs_ctrl_status_properties.sv]
`timescale 1ns/10ps
`default_nettype none
// ***************************************************************
// Port relations of the control block
// ***************************************************************
module uacs_ctrl_status_properties
   import uacs_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic        rd_i,
   input wire logic [7:0]  rdata_o,
   input wire logic        tx_buf_full_i,
   input wire logic        irq_tx_empty_o,
   input wire logic        rx_char_valid_i,
   input wire logic        rx_accept_o,
   input wire logic        rx_flush_o,
   input wire logic        rx_pin_claim_o,
   input wire logic        autobaud_done_o,
   input wire logic [15:0] autobaud_cycles_o,
   input wire logic        sleep_i,
   input wire logic        wake_o,
   input wire logic [1:0]  comm_mode_o,
   input wire logic [4:0]  samples_per_bit_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   read_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data not idle");
   empty_irq_a: assert property (irq_tx_empty_o |-> !$past(tx_buf_full_i))
      else $error("empty irq with full buffer");
   accept_gate_a: assert property (rx_accept_o |-> $past(rx_char_valid_i) && !rx_flush_o)
      else $error("char taken while off");
   claim_flush_a: assert property (rx_pin_claim_o != rx_flush_o)
      else $error("pin claim and flush agree");
   ab_done_a: assert property (autobaud_done_o |->
      $past(rx_char_valid_i) && autobaud_cycles_o >= AB_MIN_BIT_CYC)
      else $error("bad auto-baud result");
   ab_pulse_a: assert property (autobaud_done_o |=> !autobaud_done_o)
      else $error("auto-baud done too long");
   wake_sleep_a: assert property (wake_o |-> $past(sleep_i))
      else $error("wake while awake");
   sync_speed_a: assert property (comm_mode_o == CM_SYNC |->
      samples_per_bit_o == SAMPLES_NORMAL)
      else $error("double speed in sync mode");
endmodule
bind uacs_ctrl_status uacs_ctrl_status_properties i_props (.*);
`default_nettype wire

// [verification/uacs_remote_node.sv]
`timescale 1ns/10ps
`default_nettype none
// ***************************************************************
// Remote node on the receive line, idle at mark
// ***************************************************************
module uacs_remote_node (
   input  wire logic clk_i,
   output var  logic rxd_o
);
   initial rxd_o = 1'b1;
   task automatic hold(input logic lv, input int n);
      rxd_o <= lv;
      repeat (n) @(posedge clk_i);
   endtask
   task automatic brk(input int bits, input int bt);
      hold(1'b0, bits * bt);
      hold(1'b1, bt);
   endtask
   task automatic frame(input logic [7:0] b, input int bt);
      hold(1'b0, bt);
      for (int i = 0; i < 8; i++) hold(b[i], bt);
      hold(1'b1, bt);
   endtask
endmodule
`default_nettype wire

// [verification/usart_control_autobaud_status_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module usart_control_autobaud_status_tb_top
   import uacs_pkg::*;
;
   logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, sleep_i = 1'b0, t;
   logic rx_char_valid_i = 1'b0, rx_char_addr_i = 1'b0, rx_pop_i = 1'b0, tx_buf_full_i = 1'b0;
   logic ce_i = 1'b1, tx_serial_i = 1'b0, tx_shift_busy_i = 1'b0, tx_complete_i = 1'b0;
   logic tx_vector_ack_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00, rx_char_data_i = 8'h00, v, d, e;
   logic [15:0] bit_cycles_i = 16'h0010;
   logic [31:0] rnd = 32'h0;
   wire logic [7:0] rdata_o, frame_fmt_o;
   wire logic [15:0] autobaud_cycles_o;
   wire logic [4:0] samples_per_bit_o;
   wire logic [1:0] comm_mode_o;
   wire logic rxd_pin_i, irq_receive_o, irq_transmit_o, irq_tx_empty_o, rx_line_o, rx_pin_claim_o;
   wire logic rx_accept_o, rx_flush_o, txd_o, txd_oe_o, driver_enable_pin_o, wake_o, autobaud_done_o;
   int seed = 32'h7f0b, bad_count = 0, n_compared = 0, cyc = 0;
   uacs_ctrl_status i_dut (.*);
   uacs_remote_node i_node (.clk_i, .rxd_o(rxd_pin_i));
   initial forever #25 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      rnd <= $random(seed);
      {tx_serial_i, tx_shift_busy_i} <= rnd[1:0];
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         results();
      end
   end
   task automatic results();
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] dd);
      @(posedge clk_i);
      {wr_i, addr_i, wdata_i} <= {1'b1, a, dd};
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk_i);
      {rd_i, addr_i} <= {1'b1, a};
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask
   task automatic pulse(input logic [7:0] c, input logic am);
      @(posedge clk_i);
      {rx_char_valid_i, rx_char_data_i, rx_char_addr_i} <= {1'b1, c, am};
      @(posedge clk_i);
      rx_char_valid_i <= 1'b0;
   endtask
   // Flush, set mode, optional await arm, break, sync, then one char
   task automatic ab_run(input logic [7:0] m, input logic arm, input int bits, input int bt,
                         input logic [7:0] c);
      wr(OFF_ENABLE_RECEIVE_SPEED_MODE, 8'h00);
      wr(OFF_ENABLE_RECEIVE_SPEED_MODE, m);
      if (arm) wr(OFF_STATUS, 8'h01);
      i_node.brk(bits, bt);
      i_node.frame(SYNC_VALUE, bt);
      pulse(c, 1'b0);
      rd(OFF_STATUS);
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(OFF_IRQ_LB_LINE_DRIVER_MODE);
      chk(v, RST_IRQ_LB_LINE_DRIVER_MODE);
      rd(OFF_ENABLE_RECEIVE_SPEED_MODE);
      chk(v, RST_ENABLE_RECEIVE_SPEED_MODE);
      rd(OFF_FRAME_FORMAT);
      chk(v, RST_FRAME_FORMAT);
      rd(OFF_STATUS);
      chk(v, 8'h20);
      rd(4'h8 | rnd[2:0]);
      chk(v, 8'h00);
      for (int i = 0; i < 8; i++) begin
         d = rnd[7:0];
         wr(OFF_IRQ_LB_LINE_DRIVER_MODE, d);
         rd(OFF_IRQ_LB_LINE_DRIVER_MODE);
         chk(v, d);
         e = d & ((i % 4 == 1 || i % 4 == 2) ? 8'hd9 : 8'hdb);
         wr(OFF_ENABLE_RECEIVE_SPEED_MODE, e);
         wr(OFF_FRAME_FORMAT, {i[1:0], d[5:0]});
         rd(OFF_ENABLE_RECEIVE_SPEED_MODE);
         chk(v, e);
         rd(OFF_FRAME_FORMAT);
         chk(v, {i[1:0], d[5:0]} & (i % 4 == 3 ? 8'hc6 : 8'hff));
         chk(frame_fmt_o, {i[1:0], d[5:0]} & (i % 4 == 3 ? 8'hc6 : 8'hff));
         chk(comm_mode_o, i[1:0]);
         chk(samples_per_bit_o, e[1] ? 16'h8 : 16'h10);
      end
      wr(OFF_FRAME_FORMAT, 8'h03);
      wr(OFF_IRQ_LB_LINE_DRIVER_MODE, 8'h80);
      wr(OFF_ENABLE_RECEIVE_SPEED_MODE, 8'h81);
      pulse(8'h3c, 1'b0);
      rd(OFF_STATUS);
      chk(v[7], 1'b0);
      repeat (3) pulse(rnd[7:0], 1'b1);
      rd(OFF_STATUS);
      chk(v[7], 1'b1);
      chk(irq_receive_o, 1'b1);
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_i);
         rx_pop_i <= 1'b1;
         @(posedge clk_i);
         rx_pop_i <= 1'b0;
         rd(OFF_STATUS);
         chk(v[7], k == 0);
      end
      pulse(8'h11, 1'b1);
      wr(OFF_ENABLE_RECEIVE_SPEED_MODE, 8'h00);
      rd(OFF_STATUS);
      chk(v[7], 1'b0);
      wr(OFF_IRQ_LB_LINE_DRIVER_MODE, 8'h04);
      ab_run(8'h86, 1'b0, 10, 16, SYNC_VALUE);
      chk(v[1], 1'b0);
      ab_run(8'h86, 1'b0, 11, 16, SYNC_VALUE);
      chk(v[3:0], 4'h2);
      pulse(8'h12, 1'b0);
      rd(OFF_STATUS);
      chk(v[1], 1'b0);
      ab_run(8'h86, 1'b0, 11, 16, 8'ha5);
      chk(v[3], 1'b1);
      chk(irq_receive_o, 1'b1);
      wr(OFF_STATUS, 8'h08);
      rd(OFF_STATUS);
      chk(v[3], 1'b0);
      ab_run(8'h86, 1'b0, 11, 20, SYNC_VALUE);
      chk(v[3], 1'b1);
      ab_run(8'h84, 1'b1, 2, 12, 8'h3c);
      chk(v[3], 1'b1);
      ab_run(8'h84, 1'b1, 2, 16, 8'h3c);
      chk(v[3:0], 4'h2);
      wr(OFF_STATUS, 8'h02);
      rd(OFF_STATUS);
      chk(v[1], 1'b0);
      wr(OFF_IRQ_LB_LINE_DRIVER_MODE, 8'h08);
      wr(OFF_ENABLE_RECEIVE_SPEED_MODE, 8'h48);
      repeat (2) @(posedge clk_i);
      for (int k = 0; k < 8; k++) begin
         #1 t = tx_serial_i;
         @(posedge clk_i);
         #1 chk(rx_line_o, t);
         chk({txd_oe_o, txd_o}, {!t, 1'b0});
      end
      wr(OFF_IRQ_LB_LINE_DRIVER_MODE, 8'h20);
      tx_buf_full_i <= 1'b1;
      wr(OFF_ENABLE_RECEIVE_SPEED_MODE, 8'h40);
      wr(OFF_ENABLE_RECEIVE_SPEED_MODE, 8'h00);
      rd(OFF_STATUS);
      chk({txd_oe_o, irq_tx_empty_o, v[5]}, 3'b100);
      tx_buf_full_i <= 1'b0;
      for (int k = 0; k < 40 && txd_oe_o !== 1'b0; k++) @(posedge clk_i);
      repeat (2) @(posedge clk_i);
      #1 chk({txd_oe_o, irq_tx_empty_o}, 2'b01);
      // Transmit complete flag, its vector and external driver enable
      wr(OFF_IRQ_LB_LINE_DRIVER_MODE, 8'h41);
      wr(OFF_ENABLE_RECEIVE_SPEED_MODE, 8'h40);
      tx_complete_i <= 1'b1;
      @(posedge clk_i);
      tx_complete_i <= 1'b0;
      #1 t = tx_shift_busy_i;
      @(posedge clk_i);
      #1 chk({irq_transmit_o, driver_enable_pin_o}, {1'b1, t});
      @(posedge clk_i);
      tx_vector_ack_i <= 1'b1;
      @(posedge clk_i);
      tx_vector_ack_i <= 1'b0;
      rd(OFF_STATUS);
      chk({v[6], irq_transmit_o}, 2'b00);
      wr(OFF_IRQ_LB_LINE_DRIVER_MODE, 8'h10);
      wr(OFF_ENABLE_RECEIVE_SPEED_MODE, 8'h90);
      sleep_i <= 1'b1;
      i_node.hold(1'b0, 6);
      i_node.hold(1'b1, 2);
      chk(irq_receive_o, 1'b1);
      sleep_i <= 1'b0;
      rd(OFF_STATUS);
      chk(v[4], 1'b1);
      wr(OFF_STATUS, 8'h10);
      rd(OFF_STATUS);
      chk({v[4], irq_receive_o}, 2'b00);
      results();
   end
endmodule
`default_nettype wire

// [verilog/uacs_ctrl_status.sv]
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module uacs_ctrl_status
   import uacs_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              ce_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [7:0]        wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [7:0]        rdata_o,
   input  wire logic              rxd_pin_i,
   input  wire logic              sleep_i,
   input  wire logic [15:0]       bit_cycles_i,
   input  wire logic              rx_char_valid_i,
   input  wire logic [7:0]        rx_char_data_i,
   input  wire logic              rx_char_addr_i,
   input  wire logic              rx_pop_i,
   input  wire logic              tx_serial_i,
   input  wire logic              tx_shift_busy_i,
   input  wire logic              tx_buf_full_i,
   input  wire logic              tx_complete_i,
   input  wire logic              tx_vector_ack_i,
   output logic                   irq_receive_o,
   output logic                   irq_transmit_o,
   output logic                   irq_tx_empty_o,
   output logic                   rx_line_o,
   output logic                   rx_pin_claim_o,
   output logic                   rx_accept_o,
   output logic                   rx_flush_o,
   output logic                   txd_o,
   output logic                   txd_oe_o,
   output logic                   driver_enable_pin_o,
   output logic                   wake_o,
   output logic      [4:0]        samples_per_bit_o,
   output logic      [1:0]        comm_mode_o,
   output logic      [7:0]        frame_fmt_o,
   output logic                   autobaud_done_o,
   output logic      [15:0]       autobaud_cycles_o
);
   // ***************************************************************
   // Registers and decode
   // ***************************************************************
   typedef enum logic [2:0] {
      AB_IDLE = 3'h0, AB_BREAK = 3'h1, AB_SYNC = 3'h2, AB_CHAR = 3'h3, AB_HOLD = 3'h4
   } uacs_ab_e;

   uacs_interrupt_loopback_line_driver_mode_ctrl_s interrupt_loopback_line_driver_mode_ctrl_r;
   uacs_enable_and_receive_mode_ctrl_s enable_and_receive_mode_ctrl_r;
   uacs_frame_format_ctrl_s frame_format_ctrl_r;
   uacs_ab_e    ab_state_r;
   uacs_ab_e    ab_state_nxt;
   logic        rxd_meta_r;
   logic        rxd_sync_r;
   logic        line_prev_r;
   logic [1:0]  rx_count_r;
   logic        tx_done_r;
   logic        frame_start_r;
   logic        sync_incons_r;
   logic        break_seen_r;
   logic        await_break_r;
   logic        tx_active_r;
   logic [19:0] seg_cnt_r;
   logic [19:0] total_cnt_r;
   logic [2:0]  fall_cnt_r;
   logic [15:0] meas_r;

   wire wr_status = wr_i && (addr_i == OFF_STATUS);
   wire wr_interrupt_loopback_line_driver_mode_ctrl  = wr_i && (addr_i == OFF_IRQ_LB_LINE_DRIVER_MODE);
   wire wr_enable_and_receive_mode_ctrl  = wr_i && (addr_i == OFF_ENABLE_RECEIVE_SPEED_MODE);
   wire wr_frame_format_ctrl  = wr_i && (addr_i == OFF_FRAME_FORMAT);
   wire clr_tx_done     = wr_status && wdata_i[ST_TX_DONE];
   wire clr_frame_start = wr_status && wdata_i[ST_FRAME_START];
   wire clr_sync_incons = wr_status && wdata_i[ST_SYNC_INCONS];
   wire clr_break_seen  = wr_status && wdata_i[ST_BREAK_SEEN];
   wire set_await_break = wr_status && wdata_i[ST_AWAIT_BREAK];

   // ***************************************************************
   // Receive line selection and edges
   // ***************************************************************
   wire line_now  = interrupt_loopback_line_driver_mode_ctrl_r.loopback_en ? tx_serial_i : rxd_sync_r;
   wire line_fall = line_prev_r && !line_now;
   wire line_rise = !line_prev_r && line_now;

   wire lin_mode  = enable_and_receive_mode_ctrl_r.receive_speed_mode == SPD_LIN_AUTOBAUD;
   wire auto_mode = lin_mode || (enable_and_receive_mode_ctrl_r.receive_speed_mode == SPD_GENERIC_AUTOBAUD);
   wire ab_run    = auto_mode && enable_and_receive_mode_ctrl_r.receiver_on;

   // ***************************************************************
   // Receive buffer occupancy and multidrop filter
   // ***************************************************************
   wire rx_take  = enable_and_receive_mode_ctrl_r.receiver_on && rx_char_valid_i &&
                   (!enable_and_receive_mode_ctrl_r.multidrop_filter_en || rx_char_addr_i);
   wire rx_push  = rx_take && (rx_count_r != 2'h2);
   wire rx_pull  = rx_pop_i && (rx_count_r != 2'h0);
   wire [1:0] rx_count_nxt = !enable_and_receive_mode_ctrl_r.receiver_on ? 2'h0 :
                             (rx_push && !rx_pull) ? rx_count_r + 2'h1 :
                             (rx_pull && !rx_push) ? rx_count_r - 2'h1 : rx_count_r;
   wire rx_done_flag = rx_count_r != 2'h0;

   // ***************************************************************
   // Auto-baud measurement
   // ***************************************************************
   wire [20:0] break_thr   = 21'(bit_cycles_i) * 21'(BREAK_BITS);
   wire        break_long  = {1'b0, seg_cnt_r} >= break_thr;
   wire [23:0] seg_scaled  = {seg_cnt_r, 4'h0};
   wire [23:0] lin_lo      = 24'(bit_cycles_i) * 24'(LIN_SAMPLES_LO);
   wire [23:0] lin_hi      = 24'(bit_cycles_i) * 24'(LIN_SAMPLES_HI);
   wire        lin_gap_ok  = (seg_scaled >= lin_lo) && (seg_scaled <= lin_hi);
   wire [19:0] total_fin   = total_cnt_r + seg_cnt_r;
   wire [16:0] meas_wide   = 17'(total_fin >> 3);
   wire        rate_ok     = !meas_wide[16] && (meas_wide[15:0] >= AB_MIN_BIT_CYC);
   wire        seg_ovf     = seg_cnt_r == SEG_MAX;
   wire        last_fall   = fall_cnt_r == SYNC_FALLS;
   wire        gap_bad     = lin_mode && (fall_cnt_r != 3'h0) && !lin_gap_ok;
   wire        sync_fail   = (ab_state_r == AB_SYNC) &&
                             (seg_ovf || (line_fall && (gap_bad || (last_fall && !rate_ok))));
   wire        char_bad    = lin_mode && (rx_char_data_i != SYNC_VALUE);
   wire        char_seen   = (ab_state_r == AB_CHAR) && rx_char_valid_i;
   wire        char_fail   = char_seen && char_bad;
   wire        ab_error    = sync_fail || char_fail;
   wire        ab_ok       = char_seen && !char_bad;
   wire        break_ends  = (ab_state_r == AB_BREAK) && line_rise;
   wire        break_valid = break_ends && (break_long || await_break_r);

   always_comb begin
      ab_state_nxt = ab_state_r;
      unique case (ab_state_r)
         AB_IDLE: begin
            if (line_fall) begin
               ab_state_nxt = AB_BREAK;
            end
         end
         AB_BREAK: begin
            if (line_rise) begin
               ab_state_nxt = break_valid ? AB_SYNC : AB_IDLE;
            end
         end
         AB_SYNC: begin
            if (sync_fail) begin
               ab_state_nxt = AB_HOLD;
            end else if (line_fall && last_fall) begin
               ab_state_nxt = AB_CHAR;
            end
         end
         AB_CHAR: begin
            if (char_fail) begin
               ab_state_nxt = AB_HOLD;
            end else if (ab_ok) begin
               ab_state_nxt = AB_IDLE;
            end
         end
         AB_HOLD: begin
            if (clr_sync_incons) begin
               ab_state_nxt = AB_IDLE;
            end
         end
         default: begin
            ab_state_nxt = AB_IDLE;
         end
      endcase
      if (!ab_run) begin
         ab_state_nxt = AB_IDLE;
      end
   end

   wire seg_idle = ab_state_r == AB_IDLE;
   wire [19:0] seg_nxt = line_fall ? 20'h00001 : seg_idle ? 20'h00000 : // Fall cycle counts
                         (seg_ovf ? seg_cnt_r : seg_cnt_r + 20'h1);
   wire first_fall = (ab_state_r == AB_BREAK) || (fall_cnt_r == 3'h0);
   wire [19:0] total_nxt = (ab_state_r != AB_SYNC) ? 20'h00000 :
                           (line_fall && !first_fall) ? total_fin : total_cnt_r;
   wire [2:0] fall_nxt = (ab_state_r != AB_SYNC) ? 3'h0 :
                         line_fall ? fall_cnt_r + 3'h1 : fall_cnt_r;

   // ***************************************************************
   // Status flags, set wins over clear
   // ***************************************************************
   wire tx_done_nxt     = tx_complete_i || (tx_done_r && !clr_tx_done && !tx_vector_ack_i);
   wire frame_evt       = enable_and_receive_mode_ctrl_r.frame_start_detect_en && sleep_i && line_fall;
   wire frame_start_nxt = frame_evt || (frame_start_r && !clr_frame_start);
   wire sync_incons_nxt = ab_run && (ab_error || (sync_incons_r && !clr_sync_incons));
   wire break_clr       = clr_break_seen || rx_take;
   wire break_seen_nxt  = ab_run && (ab_ok || (break_seen_r && !break_clr));
   wire await_break_nxt = set_await_break || (await_break_r && !break_valid);

   // ***************************************************************
   // Transmitter pin control
   // ***************************************************************
   wire tx_drained    = !tx_shift_busy_i && !tx_buf_full_i;
   wire tx_active_nxt = enable_and_receive_mode_ctrl_r.transmitter_on || (tx_active_r && !tx_drained);
   wire drv_int       = interrupt_loopback_line_driver_mode_ctrl_r.line_driver_mode == DRV_INTERNAL;
   wire drv_ext       = interrupt_loopback_line_driver_mode_ctrl_r.line_driver_mode == DRV_EXTERNAL;
   wire tx_drive      = tx_active_r && (!drv_int || tx_shift_busy_i);
   wire txd_oe_nxt    = tx_drive && (!enable_and_receive_mode_ctrl_r.open_drain_en || !tx_serial_i);
   wire txd_nxt       = enable_and_receive_mode_ctrl_r.open_drain_en ? 1'b0 : tx_serial_i;
   wire de_pin_nxt    = drv_ext && tx_active_r && tx_shift_busy_i;

   // ***************************************************************
   // Interrupt requests and mode outputs
   // ***************************************************************
   wire irq_rx_nxt = (interrupt_loopback_line_driver_mode_ctrl_r.rx_done_irq_en && rx_done_flag) ||
                     (interrupt_loopback_line_driver_mode_ctrl_r.frame_start_irq_en && frame_start_r) ||
                     (interrupt_loopback_line_driver_mode_ctrl_r.autobaud_err_irq_en && sync_incons_r);
   wire irq_tx_nxt = interrupt_loopback_line_driver_mode_ctrl_r.tx_done_irq_en && tx_done_r;
   wire irq_de_nxt = interrupt_loopback_line_driver_mode_ctrl_r.tx_empty_irq_en && !tx_buf_full_i;
   wire async_like = frame_format_ctrl_r.comm_mode_sel != CM_SYNC;
   wire dbl_speed  = async_like && (enable_and_receive_mode_ctrl_r.receive_speed_mode == SPD_DOUBLE);
   wire [4:0] spb_nxt = dbl_speed ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
   wire is_master_spi_mode    = frame_format_ctrl_r.comm_mode_sel == CM_MASTER_SPI_MODE;
   wire [7:0] frame_format_ctrl_view = is_master_spi_mode ? {frame_format_ctrl_r[7:6], 3'h0, frame_format_ctrl_r[2:1], 1'b0} : frame_format_ctrl_r;

   wire [7:0] status_view = {rx_done_flag, tx_done_r, !tx_buf_full_i, frame_start_r,
                             sync_incons_r, 1'b0, break_seen_r, 1'b0};
   wire [7:0] rdata_nxt = !rd_i ? 8'h00 :
                          (addr_i == OFF_STATUS)        ? status_view :
                          (addr_i == OFF_IRQ_LB_LINE_DRIVER_MODE)  ? interrupt_loopback_line_driver_mode_ctrl_r :
                          (addr_i == OFF_ENABLE_RECEIVE_SPEED_MODE) ? enable_and_receive_mode_ctrl_r :
                          (addr_i == OFF_FRAME_FORMAT)  ? frame_format_ctrl_view : 8'h00;

   // ***************************************************************
   // Sequential logic
   // ***************************************************************
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rxd_meta_r  <= 1'b1;
         rxd_sync_r  <= 1'b1;
         line_prev_r <= 1'b1;
      end else if (ce_i) begin
         rxd_meta_r  <= rxd_pin_i;
         rxd_sync_r  <= rxd_meta_r;
         line_prev_r <= line_now;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         interrupt_loopback_line_driver_mode_ctrl_r <= RST_IRQ_LB_LINE_DRIVER_MODE;
         enable_and_receive_mode_ctrl_r <= RST_ENABLE_RECEIVE_SPEED_MODE;
         frame_format_ctrl_r <= RST_FRAME_FORMAT;
         rdata_o <= 8'h00;
      end else if (ce_i) begin
         if (wr_interrupt_loopback_line_driver_mode_ctrl) begin
            interrupt_loopback_line_driver_mode_ctrl_r <= wdata_i;
         end
         if (wr_enable_and_receive_mode_ctrl) begin
            enable_and_receive_mode_ctrl_r <= {wdata_i[7:6], 1'b0, wdata_i[4:0]};
         end
         if (wr_frame_format_ctrl) begin
            frame_format_ctrl_r <= wdata_i;
         end
         rdata_o <= rdata_nxt;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_count_r    <= 2'h0;
         tx_done_r     <= 1'b0;
         frame_start_r <= 1'b0;
         sync_incons_r <= 1'b0;
         break_seen_r  <= 1'b0;
         await_break_r <= 1'b0;
         tx_active_r   <= 1'b0;
      end else if (ce_i) begin
         rx_count_r    <= rx_count_nxt;
         tx_done_r     <= tx_done_nxt;
         frame_start_r <= frame_start_nxt;
         sync_incons_r <= sync_incons_nxt;
         break_seen_r  <= break_seen_nxt;
         await_break_r <= await_break_nxt;
         tx_active_r   <= tx_active_nxt;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ab_state_r  <= AB_IDLE;
         seg_cnt_r   <= 20'h00000;
         total_cnt_r <= 20'h00000;
         fall_cnt_r  <= 3'h0;
         meas_r      <= 16'h0000;
      end else if (ce_i) begin
         ab_state_r  <= ab_state_nxt;
         seg_cnt_r   <= seg_nxt;
         total_cnt_r <= total_nxt;
         fall_cnt_r  <= fall_nxt;
         if ((ab_state_r == AB_SYNC) && line_fall && last_fall) begin
            meas_r <= meas_wide[15:0];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_receive_o       <= 1'b0;
         irq_transmit_o      <= 1'b0;
         irq_tx_empty_o      <= 1'b0;
         rx_line_o           <= 1'b1;
         rx_pin_claim_o      <= 1'b0;
         rx_accept_o         <= 1'b0;
         rx_flush_o          <= 1'b1;
         txd_o               <= 1'b1;
         txd_oe_o            <= 1'b0;
         driver_enable_pin_o <= 1'b0;
         wake_o              <= 1'b0;
         samples_per_bit_o   <= SAMPLES_NORMAL;
         comm_mode_o         <= 2'h0;
         frame_fmt_o         <= RST_FRAME_FORMAT;
         autobaud_done_o     <= 1'b0;
         autobaud_cycles_o   <= 16'h0000;
      end else if (ce_i) begin
         irq_receive_o       <= irq_rx_nxt;
         irq_transmit_o      <= irq_tx_nxt;
         irq_tx_empty_o      <= irq_de_nxt;
         rx_line_o           <= line_now;
         rx_pin_claim_o      <= enable_and_receive_mode_ctrl_r.receiver_on;
         rx_accept_o         <= rx_push;
         rx_flush_o          <= !enable_and_receive_mode_ctrl_r.receiver_on;
         txd_o               <= txd_nxt;
         txd_oe_o            <= txd_oe_nxt;
         driver_enable_pin_o <= de_pin_nxt;
         wake_o              <= frame_evt;
         samples_per_bit_o   <= spb_nxt;
         comm_mode_o         <= frame_format_ctrl_r.comm_mode_sel;
         frame_fmt_o         <= frame_format_ctrl_view;
         autobaud_done_o     <= ab_ok;
         if (ab_ok) begin
            autobaud_cycles_o <= meas_r;
         end
      end
   end
endmodule
`default_nettype wire

// [verilog/uacs_pkg.sv]
`default_nettype none
package uacs_pkg;
   // ***************************************************************
   // Register map and layout
   // ***************************************************************
   localparam int unsigned ADDR_W = 4;
   localparam logic [3:0] OFF_STATUS = 4'h4;
   localparam logic [3:0] OFF_IRQ_LB_LINE_DRIVER_MODE = 4'h5;
   localparam logic [3:0] OFF_ENABLE_RECEIVE_SPEED_MODE = 4'h6;
   localparam logic [3:0] OFF_FRAME_FORMAT = 4'h7;
   localparam logic [7:0] RST_IRQ_LB_LINE_DRIVER_MODE = 8'h00;
   localparam logic [7:0] RST_ENABLE_RECEIVE_SPEED_MODE = 8'h00;
   localparam logic [7:0] RST_FRAME_FORMAT = 8'h03;
   localparam int unsigned ST_RX_DONE = 7;
   localparam int unsigned ST_TX_DONE = 6;
   localparam int unsigned ST_TX_EMPTY = 5;
   localparam int unsigned ST_FRAME_START = 4;
   localparam int unsigned ST_SYNC_INCONS = 3;
   localparam int unsigned ST_BREAK_SEEN = 1;
   localparam int unsigned ST_AWAIT_BREAK = 0;
   // ***************************************************************
   // Timing in bits, sixteenths of a bit and clock cycles
   // ***************************************************************
   localparam logic [4:0] BREAK_BITS = 5'h0b;
   localparam logic [5:0] LIN_SAMPLES_LO = 6'h1a;
   localparam logic [5:0] LIN_SAMPLES_HI = 6'h26;
   localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
   localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
   localparam logic [15:0] AB_MIN_BIT_CYC = 16'h0010;
   localparam logic [7:0] SYNC_VALUE = 8'h55;
   localparam logic [2:0] SYNC_FALLS = 3'h4;
   localparam logic [19:0] SEG_MAX = 20'hfffff;
   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [1:0] {
      SPD_NORMAL = 2'h0, SPD_DOUBLE = 2'h1, SPD_GENERIC_AUTOBAUD = 2'h2, SPD_LIN_AUTOBAUD = 2'h3
   } uacs_speed_e;
   typedef enum logic [1:0] {
      CM_ASYNC = 2'h0, CM_SYNC = 2'h1, CM_INFRARED = 2'h2, CM_MASTER_SPI_MODE = 2'h3
   } uacs_comm_e;
   typedef enum logic [1:0] {
      DRV_OFF = 2'h0, DRV_EXTERNAL = 2'h1, DRV_INTERNAL = 2'h2, DRV_RSVD = 2'h3
   } uacs_drv_e;
   typedef struct packed {
      logic       rx_done_irq_en;
      logic       tx_done_irq_en;
      logic       tx_empty_irq_en;
      logic       frame_start_irq_en;
      logic       loopback_en;
      logic       autobaud_err_irq_en;
      uacs_drv_e  line_driver_mode;
   } uacs_interrupt_loopback_line_driver_mode_ctrl_s;
   typedef struct packed {
      logic        receiver_on;
      logic        transmitter_on;
      logic        unused;
      logic        frame_start_detect_en;
      logic        open_drain_en;
      uacs_speed_e receive_speed_mode;
      logic        multidrop_filter_en;
   } uacs_enable_and_receive_mode_ctrl_s;
   typedef struct packed {
      uacs_comm_e comm_mode_sel;
      logic [1:0] parity_sel;
      logic       stop_bit_sel;
      logic [2:0] char_width_sel;
   } uacs_frame_format_ctrl_s;
endpackage
`default_nettype wire
